// ---- include/adcwc_cfg.svh ----
/*
  Offsets, field positions, reset values and counts of the converter
  control block. Definitions only; included by the RTL.
*/
`ifndef ADCWC_CFG_SVH
`define ADCWC_CFG_SVH

// Register offsets
`define ADCWC_OFF_CTRL1      8'hb2
`define ADCWC_OFF_CTRL2      8'hb3
`define ADCWC_OFF_RES_HI     8'hb4
`define ADCWC_OFF_RES_LO     8'hb5
`define ADCWC_OFF_WIN_HI     8'hb6
`define ADCWC_OFF_WIN_LO     8'hb7

// First control register fields
`define ADCWC_C1_BUSY        7
`define ADCWC_C1_EOC         6
`define ADCWC_C1_REPEAT      5
`define ADCWC_C1_EXT         4
`define ADCWC_C1_QUAL        3
`define ADCWC_C1_MATCH       2
`define ADCWC_C1_POWER       1
`define ADCWC_C1_IO          0

// Second control register fields
`define ADCWC_C2_FMT         7
`define ADCWC_C2_CHAN_HI     6
`define ADCWC_C2_CHAN_LO     4
`define ADCWC_C2_PRE_HI      3
`define ADCWC_C2_PRE_LO      0

// Reset values
`define ADCWC_RESET_BYTE     8'h00
`define ADCWC_RESET_RESULT   10'h000
`define ADCWC_READ_UNMAPPED  8'h00

// Conversion timing in converter clocks
`define ADCWC_SAMPLE_CLKS    4'h5
`define ADCWC_APPROX_CLKS    4'ha
`define ADCWC_TOTAL_CLKS     5'h10
`define ADCWC_LAST_CLK       4'hf

`endif

// ---- include/adcwc_pkg.sv ----
/*
  Types of the converter control block: state records and the phase
  code shown to the analog core. Assumes adcwc_cfg.svh on the include path.
*/
package adcwc_pkg;

  // Phase of the conversion seen by the analog core
  typedef enum logic [1:0] {
    ADCWC_IDLE   = 2'b00,
    ADCWC_SAMPLE = 2'b01,
    ADCWC_APPROX = 2'b10,
    ADCWC_FINAL  = 2'b11
  } adcwc_phase_e;

  // Whole state of the control block
  typedef struct packed {
    logic       start_busy_bit;
    logic       eoc;
    logic       repeat_mode_bit;
    logic       external_trigger_enable;
    logic       interrupt_qualify_bit;
    logic       window_match_flag;
    logic       converter_power_bit;
    logic       inside_outside_select;
    logic       output_format_bit;
    logic [2:0] channel_select_field;
    logic [3:0] clock_prescale_field;
    logic [9:0] result;
    logic [7:0] window_upper_limit;
    logic [7:0] window_lower_limit;
    logic [3:0] conv_cnt;
    logic [2:0] conv_chan;
    logic       ext_prev;
    logic [7:0] rdata;
  } adcwc_state_s;

  // Prescaler state
  typedef struct packed {
    logic [3:0] cnt;
  } adcwc_div_s;

endpackage

// ---- rtl/adcwc_prescale.sv ----
/*
  Converter clock prescaler: a one-cycle tick every N+1 machine cycles.
  Assumes a reset already synchronised to clk; clear holds it at phase 0.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adcwc_cfg.svh"

module adcwc_prescale
  import adcwc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       clear,
  input  wire logic [3:0] prescale,
  // Converter clock enable
  output logic            tick
);

  adcwc_div_s s_q;
  adcwc_div_s s_d;

  always_comb begin
    s_d = s_q;
    if (clear || s_q.cnt == prescale) begin
      s_d.cnt = 4'h0;
    end else begin
      s_d.cnt = s_q.cnt + 4'h1;
    end
  end

  assign tick = !clear && (s_q.cnt == prescale);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_div_period;
    tick && !clear && prescale == $past(prescale) |-> $past(s_q.cnt) == prescale - 4'h1
      || prescale == 4'h0;
  endproperty
  a_div_period: assert property (p_div_period)
    else $error("prescaler tick not at N+1 spacing");

endmodule // adcwc_prescale

`default_nettype wire

// ---- rtl/adcwc_top.sv ----
/*
  Control and result logic of a 10-bit successive approximation converter:
  six byte registers, software or external-edge start, single and repeat
  modes, power abort, channel select, prescaler, result format and window
  comparator. Assumes a register master per the plain strobe port, an
  analog core that holds a valid result on core_result during the final
  converter clock, and an interrupt enable held outside this block.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adcwc_cfg.svh"

// Summary of operation
// - Writing start 0 to 1 starts; bit stays set through conversion
// - Hardware clears start/busy when a single-mode conversion completes
// - Completion sets the conversion-done flag, the interrupt source
// - Repeat mode reruns conversions back to back; else one only
// - Leaving repeat mode finishes the current conversion, then halts
// - External falling edge starts when enabled; ignored otherwise
// - External start sets busy; software start still works then
// - Qualify set: interrupt only with done and window match both set
// - Qualify clear: interrupt every time done is set
// - Window match flag updated at end of every conversion
// - Power bit needed; clearing it aborts and clears busy
// - Select 1 looks outside window, 0 inside
// - All registers reset to zero
// - Format 1: high byte holds result bits 9 and 8 only
// - Format 0: high byte holds result bits 9 down to 2
// - Channel field picks input; takes effect at next start
// - Converter clock is machine clock divided by N+1
// - Low byte always holds result bits 7 down to 0
// - Limits compare with result bits 9 down to 2
// - Match equals select xor upper-less xor lower-less, unsigned
// - Conversion lasts sixteen converter clocks; done on the last
// - Five clocks sampling, ten clocks approximation
// - Repeat restarts right after completion; busy looks steady
module adcwc_top
  import adcwc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  // External start and interrupt
  input  wire logic       ext_start_n,
  input  wire logic       converter_interrupt_enable,
  output logic            adc_irq,
  // Analog core
  output logic            core_power,
  output logic [2:0]      core_channel,
  output adcwc_phase_e    core_phase,
  input  wire logic [9:0] core_result
);

  function automatic logic window_hit(input logic io, input logic [7:0] hi,
                                      input logic [7:0] lo, input logic [9:0] res);
    window_hit = io ^ (hi < res[9:2]) ^ (lo < res[9:2]);
  endfunction

  // High result byte in either format
  function automatic logic [7:0] high_byte(input logic fmt, input logic [9:0] res);
    high_byte = fmt ? {6'h00, res[9:8]} : res[9:2];
  endfunction

  logic [1:0]   rst_sync_q;
  logic         rst_i_n;
  adcwc_state_s s_q;
  adcwc_state_s s_d;
  logic         tick;
  logic         div_clear;
  logic         wr1;
  logic         wr2;
  logic         power_nx;
  logic         ext_fall;
  logic         sw_start;
  logic         hw_start;
  logic         done;
  logic         restart;
  logic         start;

  // Release of the asynchronous reset, two stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_i_n = rst_sync_q[1];

  // Divider held while idle; it wraps on the done tick, so a restart needs no clear.
  // Feeding restart back here would close a loop through tick and done.
  assign div_clear = !s_q.start_busy_bit;

  adcwc_prescale u_prescale (
    .clk      (clk),
    .rst_n    (rst_i_n),
    .clear    (div_clear),
    .prescale (s_q.clock_prescale_field),
    .tick     (tick)
  );

  always_comb begin
    s_d      = s_q;
    wr1      = reg_wr && (reg_addr == `ADCWC_OFF_CTRL1);
    wr2      = reg_wr && (reg_addr == `ADCWC_OFF_CTRL2);
    power_nx = wr1 ? reg_wdata[`ADCWC_C1_POWER] : s_q.converter_power_bit;
    ext_fall = s_q.ext_prev && !ext_start_n;
    sw_start = wr1 && reg_wdata[`ADCWC_C1_BUSY] && !s_q.start_busy_bit;
    hw_start = s_q.external_trigger_enable && ext_fall && !s_q.start_busy_bit;
    done     = s_q.start_busy_bit && tick && (s_q.conv_cnt == `ADCWC_LAST_CLK)
               && power_nx;

    // Plain writable fields
    if (wr1) begin
      s_d.repeat_mode_bit         = reg_wdata[`ADCWC_C1_REPEAT];
      s_d.external_trigger_enable = reg_wdata[`ADCWC_C1_EXT];
      s_d.interrupt_qualify_bit   = reg_wdata[`ADCWC_C1_QUAL];
      s_d.converter_power_bit     = reg_wdata[`ADCWC_C1_POWER];
      s_d.inside_outside_select   = reg_wdata[`ADCWC_C1_IO];
    end
    if (wr2) begin
      s_d.output_format_bit    = reg_wdata[`ADCWC_C2_FMT];
      s_d.channel_select_field = reg_wdata[`ADCWC_C2_CHAN_HI:`ADCWC_C2_CHAN_LO];
      s_d.clock_prescale_field = reg_wdata[`ADCWC_C2_PRE_HI:`ADCWC_C2_PRE_LO];
    end
    if (reg_wr && reg_addr == `ADCWC_OFF_WIN_HI) begin
      s_d.window_upper_limit = reg_wdata;
    end
    if (reg_wr && reg_addr == `ADCWC_OFF_WIN_LO) begin
      s_d.window_lower_limit = reg_wdata;
    end

    // Repeat uses the mode in force at completion
    restart = done && s_d.repeat_mode_bit;
    start   = (sw_start || hw_start || restart) && power_nx;

    if (!power_nx) begin
      s_d.start_busy_bit = 1'b0;
      s_d.conv_cnt       = 4'h0;
    end else if (start) begin
      // Busy stays set across a restart
      s_d.start_busy_bit = 1'b1;
      s_d.conv_cnt       = 4'h0;
      s_d.conv_chan      = s_d.channel_select_field;
    end else if (done) begin
      s_d.start_busy_bit = 1'b0;
    end else if (s_q.start_busy_bit && tick) begin
      s_d.conv_cnt = s_q.conv_cnt + 4'h1;
    end

    if (done) begin
      s_d.result            = core_result;
      s_d.window_match_flag = window_hit(s_d.inside_outside_select,
                                         s_d.window_upper_limit,
                                         s_d.window_lower_limit, core_result);
    end

    s_d.eoc = done || (s_q.eoc && !(wr1 && !reg_wdata[`ADCWC_C1_EOC]));

    s_d.ext_prev = ext_start_n;

    // Read data stand one cycle, then return to zero
    s_d.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `ADCWC_OFF_CTRL1: s_d.rdata = {s_q.start_busy_bit, s_q.eoc, s_q.repeat_mode_bit,
                                       s_q.external_trigger_enable,
                                       s_q.interrupt_qualify_bit, s_q.window_match_flag,
                                       s_q.converter_power_bit, s_q.inside_outside_select};
        `ADCWC_OFF_CTRL2: s_d.rdata = {s_q.output_format_bit, s_q.channel_select_field,
                                       s_q.clock_prescale_field};
        `ADCWC_OFF_RES_HI: s_d.rdata = high_byte(s_q.output_format_bit, s_q.result);
        `ADCWC_OFF_RES_LO: s_d.rdata = s_q.result[7:0];
        `ADCWC_OFF_WIN_HI: s_d.rdata = s_q.window_upper_limit;
        `ADCWC_OFF_WIN_LO: s_d.rdata = s_q.window_lower_limit;
        default:           s_d.rdata = `ADCWC_READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      s_q          <= '0;
      s_q.ext_prev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Phase seen by the analog core
  always_comb begin
    if (!s_q.start_busy_bit) begin
      core_phase = ADCWC_IDLE;
    end else if (s_q.conv_cnt < `ADCWC_SAMPLE_CLKS) begin
      core_phase = ADCWC_SAMPLE;
    end else if (s_q.conv_cnt < `ADCWC_SAMPLE_CLKS + `ADCWC_APPROX_CLKS) begin
      core_phase = ADCWC_APPROX;
    end else begin
      core_phase = ADCWC_FINAL;
    end
  end

  assign core_power   = s_q.converter_power_bit;
  assign core_channel = s_q.conv_chan;
  assign reg_rdata    = s_q.rdata;

  assign adc_irq = converter_interrupt_enable && s_q.eoc
                   && (!s_q.interrupt_qualify_bit || s_q.window_match_flag);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_i_n);

  property p_sw_start;
    wr1 && reg_wdata[`ADCWC_C1_BUSY] && reg_wdata[`ADCWC_C1_POWER] && !s_q.start_busy_bit
      |=> s_q.start_busy_bit && s_q.conv_cnt == 4'h0;
  endproperty
  a_sw_start: assert property (p_sw_start)
    else $error("software start did not set busy");

  property p_busy_hold;
    s_q.start_busy_bit && !done && power_nx |=> s_q.start_busy_bit;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy dropped during conversion");

  property p_single_end;
    done && !s_d.repeat_mode_bit |=> !s_q.start_busy_bit && s_q.eoc;
  endproperty
  a_single_end: assert property (p_single_end)
    else $error("single conversion did not end with done set");

  property p_repeat;
    done && s_d.repeat_mode_bit |=> s_q.start_busy_bit && s_q.conv_cnt == 4'h0 && s_q.eoc;
  endproperty
  a_repeat: assert property (p_repeat)
    else $error("repeat mode did not restart at once");

  property p_ext_start;
    s_q.external_trigger_enable && s_q.ext_prev && !ext_start_n && power_nx
      && !s_q.start_busy_bit |=> s_q.start_busy_bit;
  endproperty
  a_ext_start: assert property (p_ext_start)
    else $error("external edge did not start");

  property p_ext_ignore;
    !s_q.external_trigger_enable && !s_q.start_busy_bit && !wr1 |=> !s_q.start_busy_bit;
  endproperty
  a_ext_ignore: assert property (p_ext_ignore)
    else $error("start without trigger");

  property p_abort;
    wr1 && !reg_wdata[`ADCWC_C1_POWER] |=> !s_q.start_busy_bit && core_phase == ADCWC_IDLE
      && s_q.eoc == ($past(s_q.eoc) && $past(reg_wdata[`ADCWC_C1_EOC]));
  endproperty
  a_abort: assert property (p_abort)
    else $error("power off did not abort");

  property p_match;
    done |=> s_q.result == $past(core_result)
      && s_q.window_match_flag == (s_q.inside_outside_select
      ^ (s_q.window_upper_limit < s_q.result[9:2])
      ^ (s_q.window_lower_limit < s_q.result[9:2]));
  endproperty
  a_match: assert property (p_match)
    else $error("window match or result wrong");

  property p_qual;
    adc_irq && s_q.interrupt_qualify_bit |-> s_q.eoc && s_q.window_match_flag;
  endproperty
  a_qual: assert property (p_qual)
    else $error("qualified interrupt without match");

  property p_eoc_hold;
    s_q.eoc && !(wr1 && !reg_wdata[`ADCWC_C1_EOC]) |=> s_q.eoc;
  endproperty
  a_eoc_hold: assert property (p_eoc_hold)
    else $error("done flag lost without a clear");

  property p_read_hi;
    reg_rd && reg_addr == `ADCWC_OFF_RES_HI |=>
      reg_rdata == ($past(s_q.output_format_bit) ? {6'h00, $past(s_q.result[9:8])}
                                                 : $past(s_q.result[9:2]));
  endproperty
  a_read_hi: assert property (p_read_hi)
    else $error("high result byte format wrong");

  property p_done_last;
    $rose(s_q.start_busy_bit) && s_q.clock_prescale_field == 4'h0 |-> ##15 (done
      || !s_q.converter_power_bit || s_q.clock_prescale_field != 4'h0);
  endproperty
  a_done_last: assert property (p_done_last)
    else $error("done not sixteen converter clocks after start");

  property p_unqual;
    converter_interrupt_enable && s_q.eoc && !s_q.interrupt_qualify_bit |-> adc_irq;
  endproperty
  a_unqual: assert property (p_unqual)
    else $error("unqualified done did not raise the interrupt");

  property p_read_lo;
    reg_rd && reg_addr == `ADCWC_OFF_RES_LO |=> reg_rdata == $past(s_q.result[7:0]);
  endproperty
  a_read_lo: assert property (p_read_lo)
    else $error("low result byte wrong");

  property p_chan_hold;
    s_q.start_busy_bit && !start |=> $stable(s_q.conv_chan);
  endproperty
  a_chan_hold: assert property (p_chan_hold)
    else $error("channel changed inside a conversion");

  property p_power_idle;
    !s_q.converter_power_bit |-> !s_q.start_busy_bit && core_phase == ADCWC_IDLE;
  endproperty
  a_power_idle: assert property (p_power_idle)
    else $error("converter busy without power");

  property p_repeat_hold;
    s_q.start_busy_bit && s_q.repeat_mode_bit && !wr1 |=> s_q.start_busy_bit;
  endproperty
  a_repeat_hold: assert property (p_repeat_hold)
    else $error("repeat mode dropped busy");

endmodule // adcwc_top

`default_nettype wire

// ---- tb/adcwc_core_model.sv ----
/*
  Behavioural analog core: holds the selected channel level taken in the
  sample phase and shows it only in the final phase.
  Assumes the phase code and channel ports of adcwc_top.
*/
`timescale 1ns/1ps
`default_nettype none

module adcwc_core_model
  import adcwc_pkg::*;
(
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // Control from the block
  input  wire logic            core_power,
  input  wire logic [2:0]      core_channel,
  input  wire logic [1:0]      core_phase,
  // Channel levels and result
  input  wire logic [7:0][9:0] level,
  output logic [9:0]           core_result
);
  logic [9:0] held_q;
  logic [9:0] junk_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held_q <= 10'h000;
      junk_q <= 10'h2aa;
    end else begin
      junk_q <= ~junk_q;
      if (core_power && core_phase == ADCWC_SAMPLE) begin
        held_q <= level[core_channel];
      end
    end
  end

  // Valid only on the final clock; toggling junk exposes a late latch
  assign core_result = (core_power && core_phase == ADCWC_FINAL) ? held_q : junk_q;
endmodule // adcwc_core_model
`default_nettype wire

// ---- tb/testbench.sv ----
/*
  Self-checking bench: register access, single, repeat and external starts,
  power abort, window compare and result format.
  Assumes adcwc_top and the behavioural analog core model.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench
  import adcwc_pkg::*;
();
  localparam int WARMUP = 20;
  logic            clk;
  logic            rst_n;
  logic [7:0]      reg_addr;
  logic [7:0]      reg_wdata;
  logic            reg_wr;
  logic            reg_rd;
  logic [7:0]      reg_rdata;
  logic            ext_start_n;
  logic            irq_en;
  logic            adc_irq;
  logic            core_power;
  logic [2:0]      core_channel;
  adcwc_phase_e    core_phase;
  logic [9:0]      core_result;
  logic [7:0][9:0] level;
  int              err_total = 0;
  int              num_checks = 0;

  adcwc_top u_dut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_start_n(ext_start_n), .converter_interrupt_enable(irq_en),
    .adc_irq(adc_irq), .core_power(core_power), .core_channel(core_channel),
    .core_phase(core_phase), .core_result(core_result)
  );

  adcwc_core_model u_core (
    .clk(clk), .rst_n(rst_n), .core_power(core_power),
    .core_channel(core_channel), .core_phase(core_phase), .level(level),
    .core_result(core_result)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask

  // Expected match on result bits 9..2
  function automatic logic win(input logic io, input logic [7:0] hi,
                               input logic [7:0] lo, input logic [9:0] r);
    return io ^ (hi < r[9:2]) ^ (lo < r[9:2]);
  endfunction

  initial begin
    int           i;
    int           t;
    logic [3:0]   n;
    logic         fmt;
    logic         io;
    logic         q;
    logic         en;
    logic         m;
    logic         pm;
    logic [7:0]   c1;
    adcwc_phase_e ph;
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ext_start_n = 1'b1;
    irq_en = 1'b0;
    pm = 1'b0;
    for (i = 0; i < 8; i++) begin
      level[i] = {8'(i) * 8'h24, 2'(i)};
    end
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (i = 0; i < 6; i++) begin
      rd(8'hb2 + 8'(i), 8'h00, "reset value");
    end
    wr(8'hb4, 8'hff);
    wr(8'hb1, 8'hff);
    rd(8'hb4, 8'h00, "result write ignored");
    rd(8'hb1, 8'h00, "unmapped");
    wr(8'hb2, 8'h80);
    rd(8'hb2, 8'h00, "start without power");
    wr(8'hb2, 8'h02);
    repeat (WARMUP) @(posedge clk);
    wr(8'hb6, 8'ha0);
    wr(8'hb7, 8'h40);
    rd(8'hb6, 8'ha0, "upper limit");
    for (i = 0; i < 8; i++) begin
      n = 4'(i * 2);
      fmt = i[0];
      io = i[1];
      q = i[2];
      en = (i % 3) != 0;
      t = 16 * (n + 1);
      m = win(io, 8'ha0, 8'h40, level[i]);
      c1 = {4'h0, q, 1'b0, 1'b1, io};
      wr(8'hb3, {fmt, 3'(i), n});
      irq_en <= en;
      wr(8'hb2, c1 | 8'h80);
      wr(8'hb2, c1);
      wr(8'hb3, {fmt, 3'(i + 1), n});
      repeat (t - 6) @(posedge clk);
      rd(8'hb2, c1 | 8'h80 | {5'h00, pm, 2'h0}, "busy on last clock");
      rd(8'hb2, c1 | 8'h40 | {5'h00, m, 2'h0}, "done flags");
      chk("irq", {7'h00, en & (m | ~q)}, {7'h00, adc_irq});
      rd(8'hb4, fmt ? {6'h00, level[i][9:8]} : level[i][9:2], "high byte");
      rd(8'hb5, level[i][7:0], "low byte");
      wr(8'hb2, c1);
      #1;
      chk("irq cleared", 8'h00, {7'h00, adc_irq});
      pm = m;
    end
    wr(8'hb3, 8'h00);
    wr(8'hb2, 8'h02);
    @(posedge clk);
    ext_start_n <= 1'b0;
    @(posedge clk);
    ext_start_n <= 1'b1;
    rd(8'hb2, 8'h06, "external ignored");
    wr(8'hb2, 8'h12);
    @(posedge clk);
    ext_start_n <= 1'b0;
    for (i = 1; i < 18; i++) begin
      @(posedge clk);
      ext_start_n <= 1'b1;
      #1;
      ph = (i > 16) ? ADCWC_IDLE : (i == 16) ? ADCWC_FINAL : (i > 5) ? ADCWC_APPROX : ADCWC_SAMPLE;
      chk("phase", {6'h00, ph}, {6'h00, core_phase});
    end
    rd(8'hb2, 8'h52, "external done");
    wr(8'hb2, 8'ha2);
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      #1;
      chk("repeat running", 8'h01, {7'h00, core_phase !== ADCWC_IDLE});
    end
    wr(8'hb2, 8'h02);
    #1;
    chk("finish current", 8'h01, {7'h00, core_phase !== ADCWC_IDLE});
    i = 0;
    while (core_phase !== ADCWC_IDLE && i < 20) begin
      @(posedge clk);
      #1;
      i++;
    end
    chk("halt bound", 8'h01, {7'h00, i < 20});
    repeat (20) @(posedge clk);
    rd(8'hb2, 8'h42, "single after repeat");
    wr(8'hb2, 8'h82);
    repeat (5) @(posedge clk);
    wr(8'hb2, 8'h00);
    #1;
    chk("abort phase", {6'h00, ADCWC_IDLE}, {6'h00, core_phase});
    chk("power pin", 8'h00, {7'h00, core_power});
    repeat (30) @(posedge clk);
    rd(8'hb2, 8'h00, "abort no done");
    test_done();
  end

  // Whole run is under fifteen hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("Watchdog expired");
    test_done();
  end
endmodule // testbench
`default_nettype wire
